// ==== hw/pwrmon_adc_setup.v ====
// converter setup, sequencing and result registers of a power monitor
// assumes a two-wire serial host link sampled by core_clk and
// a converter front end delivering samples on core_clk
`timescale 1ns/100ps
`include "pwrmon_defines.vh"

module pwrmon_adc_setup #(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEF,
    parameter [17:0] CT_CYC_0 = `CT_US_0 * `CLK_MHZ,
    parameter [17:0] CT_CYC_1 = `CT_US_1 * `CLK_MHZ,
    parameter [17:0] CT_CYC_2 = `CT_US_2 * `CLK_MHZ,
    parameter [17:0] CT_CYC_3 = `CT_US_3 * `CLK_MHZ,
    parameter [17:0] CT_CYC_4 = `CT_US_4 * `CLK_MHZ,
    parameter [17:0] CT_CYC_5 = `CT_US_5 * `CLK_MHZ,
    parameter [17:0] CT_CYC_6 = `CT_US_6 * `CLK_MHZ,
    parameter [17:0] CT_CYC_7 = `CT_US_7 * `CLK_MHZ
) (
    input wire core_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    input wire [15:0] rail_sample,
    input wire [15:0] sense_sample,
    input wire [15:0] temp_sample,
    output wire sda_out,
    output wire sda_oe_n,
    output wire sense_range_select,
    output wire conv_active,
    output wire [1:0] conv_chan,
    output wire conv_ready,
    output wire [15:0] current_result,
    output wire [15:0] temp_result
);

    localparam [3:0] LS_IDLE = 4'h0;
    localparam [3:0] LS_ADDR = 4'h1;
    localparam [3:0] LS_ADDR_ACK = 4'h2;
    localparam [3:0] LS_PTR = 4'h3;
    localparam [3:0] LS_PTR_ACK = 4'h4;
    localparam [3:0] LS_WDATA = 4'h5;
    localparam [3:0] LS_WDATA_ACK = 4'h6;
    localparam [3:0] LS_RDATA = 4'h7;
    localparam [3:0] LS_RACK = 4'h8;
    localparam SEQ_IDLE = 1'b0;
    localparam SEQ_CONV = 1'b1;

    // ===========================================
    // link pin synchronisers
    reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
    reg sda_s1_ff, sda_s2_ff, sda_s3_ff;
    wire scl_rise, scl_fall, start_cond, stop_cond;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
        end else begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
        end
    end

    assign scl_rise = scl_s2_ff & ~scl_s3_ff;
    assign scl_fall = ~scl_s2_ff & scl_s3_ff;
    assign start_cond = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
    assign stop_cond = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

    // ===========================================
    // registers and read mux
    reg [15:0] setup_ff;
    reg [14:0] cal_ff;
    reg range_ff;
    reg [7:0] ptr_ff;
    reg [7:0] wr_hi_ff;
    reg [7:0] shift_ff;
    reg [3:0] lstate_ff;
    reg [3:0] bit_cnt_ff;
    reg rw_ff, byte_hi_ff, nack_ff;
    reg [15:0] tx_ff;
    reg sda_oe_n_ff, sda_out_ff;
    reg [15:0] rd_word;
    wire [15:0] sense_res, rail_res;
    wire [15:0] wr_data;
    wire wr_stb, setup_wr;

    assign wr_stb = scl_fall & (lstate_ff == LS_WDATA) &
                    (bit_cnt_ff == 4'h8) & ~byte_hi_ff;
    assign wr_data = {wr_hi_ff, shift_ff};
    assign setup_wr = wr_stb & (ptr_ff == `REG_SETUP);

    always @* begin
        case (ptr_ff)
            `REG_SYSCFG: rd_word = {11'h0, range_ff, 4'h0};
            `REG_SETUP: rd_word = setup_ff;
            `REG_CAL: rd_word = {1'b0, cal_ff};
            `REG_SENSE: rd_word = sense_res;
            `REG_RAIL: rd_word = rail_res;
            default: rd_word = 16'h0;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_ff <= `SETUP_RST;
            cal_ff <= `CAL_RST;
            range_ff <= `RANGE_RST;
        end else if (wr_stb) begin
            case (ptr_ff)
                `REG_SYSCFG: range_ff <= wr_data[`B_RANGE];
                `REG_SETUP: setup_ff <= wr_data;
                `REG_CAL: cal_ff <= wr_data[`F_CAL];
                default: range_ff <= range_ff;
            endcase
        end
    end

    // ===========================================
    // serial link engine
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lstate_ff <= LS_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h0;
            ptr_ff <= 8'h0;
            wr_hi_ff <= 8'h0;
            rw_ff <= 1'b0;
            byte_hi_ff <= 1'b1;
            nack_ff <= 1'b0;
            tx_ff <= 16'h0;
            sda_oe_n_ff <= 1'b1;
            sda_out_ff <= 1'b0;
        end else if (start_cond) begin
            lstate_ff <= LS_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_n_ff <= 1'b1;
        end else if (stop_cond) begin
            lstate_ff <= LS_IDLE;
            sda_oe_n_ff <= 1'b1;
        end else if (scl_rise) begin
            if (lstate_ff == LS_ADDR || lstate_ff == LS_PTR ||
                lstate_ff == LS_WDATA) begin
                shift_ff <= {shift_ff[6:0], sda_s2_ff};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            if (lstate_ff == LS_RACK)
                nack_ff <= sda_s2_ff;
        end else if (scl_fall) begin
            case (lstate_ff)
                LS_ADDR: begin
                    if (bit_cnt_ff == 4'h8) begin
                        if (shift_ff[7:1] == DEV_ADDR) begin
                            sda_oe_n_ff <= 1'b0;
                            rw_ff <= shift_ff[0];
                            lstate_ff <= LS_ADDR_ACK;
                        end else begin
                            lstate_ff <= LS_IDLE;
                        end
                    end
                end
                LS_ADDR_ACK: begin
                    bit_cnt_ff <= 4'h0;
                    if (rw_ff) begin
                        // open drain: a one is sent by releasing
                        sda_oe_n_ff <= rd_word[15];
                        tx_ff <= {rd_word[14:0], 1'b0};
                        lstate_ff <= LS_RDATA;
                    end else begin
                        sda_oe_n_ff <= 1'b1;
                        lstate_ff <= LS_PTR;
                    end
                end
                LS_PTR: begin
                    if (bit_cnt_ff == 4'h8) begin
                        ptr_ff <= shift_ff;
                        sda_oe_n_ff <= 1'b0;
                        lstate_ff <= LS_PTR_ACK;
                    end
                end
                LS_PTR_ACK: begin
                    sda_oe_n_ff <= 1'b1;
                    bit_cnt_ff <= 4'h0;
                    byte_hi_ff <= 1'b1;
                    lstate_ff <= LS_WDATA;
                end
                LS_WDATA: begin
                    if (bit_cnt_ff == 4'h8) begin
                        if (byte_hi_ff)
                            wr_hi_ff <= shift_ff;
                        sda_oe_n_ff <= 1'b0;
                        lstate_ff <= LS_WDATA_ACK;
                    end
                end
                LS_WDATA_ACK: begin
                    sda_oe_n_ff <= 1'b1;
                    bit_cnt_ff <= 4'h0;
                    byte_hi_ff <= ~byte_hi_ff;
                    lstate_ff <= LS_WDATA;
                end
                LS_RDATA: begin
                    if (bit_cnt_ff == 4'h7) begin
                        sda_oe_n_ff <= 1'b1;
                        lstate_ff <= LS_RACK;
                    end else begin
                        sda_oe_n_ff <= tx_ff[15];
                        tx_ff <= {tx_ff[14:0], 1'b0};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                end
                LS_RACK: begin
                    bit_cnt_ff <= 4'h0;
                    if (nack_ff) begin
                        lstate_ff <= LS_IDLE;
                    end else begin
                        sda_oe_n_ff <= tx_ff[15];
                        tx_ff <= {tx_ff[14:0], 1'b0};
                        lstate_ff <= LS_RDATA;
                    end
                end
                default: lstate_ff <= LS_IDLE;
            endcase
        end
    end

    // ===========================================
    // mode decode
    wire [3:0] mode;
    wire [2:0] chan_mask;
    wire continuous, shutdown;

    assign mode = setup_ff[`F_MODE];
    // code Eh is taken as all three channels, as printed
    assign chan_mask = (mode == `MODE_ALL_CONT) ? 3'h7 : mode[2:0];
    assign continuous = mode[3];
    assign shutdown = (chan_mask == 3'h0);

    // ===========================================
    // conversion sequencer
    reg seq_ff;
    reg pend_ff;
    reg [1:0] ch_ff;
    reg [17:0] timer_ff;
    reg [10:0] samp_cnt_ff;
    reg conv_ready_ff;
    reg [1:0] first_ch, nxt_ch, load_ch;
    reg has_next;
    reg [2:0] ct_sel;
    reg [17:0] ct_cyc;
    reg [10:0] avg_last;
    reg [3:0] avg_shift;
    wire sample_vld, at_last, pass_done;

    // fixed order: rail, sense, temperature
    always @* begin
        first_ch = chan_mask[0] ? 2'd0 : (chan_mask[1] ? 2'd1 : 2'd2);
        has_next = 1'b0;
        nxt_ch = 2'd2;
        case (ch_ff)
            2'd0: begin
                has_next = chan_mask[1] | chan_mask[2];
                nxt_ch = chan_mask[1] ? 2'd1 : 2'd2;
            end
            2'd1: has_next = chan_mask[2];
            default: has_next = 1'b0;
        endcase
    end

    always @* begin
        if (seq_ff == SEQ_IDLE || (at_last && !has_next))
            load_ch = first_ch;
        else if (at_last)
            load_ch = nxt_ch;
        else
            load_ch = ch_ff;
        case (load_ch)
            2'd0: ct_sel = setup_ff[`F_RAIL_CT];
            2'd1: ct_sel = setup_ff[`F_SENSE_CT];
            default: ct_sel = setup_ff[`F_TEMP_CT];
        endcase
        case (ct_sel)
            3'h0: ct_cyc = CT_CYC_0;
            3'h1: ct_cyc = CT_CYC_1;
            3'h2: ct_cyc = CT_CYC_2;
            3'h3: ct_cyc = CT_CYC_3;
            3'h4: ct_cyc = CT_CYC_4;
            3'h5: ct_cyc = CT_CYC_5;
            3'h6: ct_cyc = CT_CYC_6;
            default: ct_cyc = CT_CYC_7;
        endcase
    end

    // one count for all enabled channels
    always @* begin
        case (setup_ff[`F_AVG])
            3'h0: begin avg_last = `AVG_LAST_0; avg_shift = `AVG_SH_0; end
            3'h1: begin avg_last = `AVG_LAST_1; avg_shift = `AVG_SH_1; end
            3'h2: begin avg_last = `AVG_LAST_2; avg_shift = `AVG_SH_2; end
            3'h3: begin avg_last = `AVG_LAST_3; avg_shift = `AVG_SH_3; end
            3'h4: begin avg_last = `AVG_LAST_4; avg_shift = `AVG_SH_4; end
            3'h5: begin avg_last = `AVG_LAST_5; avg_shift = `AVG_SH_5; end
            3'h6: begin avg_last = `AVG_LAST_6; avg_shift = `AVG_SH_6; end
            default: begin avg_last = `AVG_LAST_7; avg_shift = `AVG_SH_7; end
        endcase
    end

    assign sample_vld = (seq_ff == SEQ_CONV) & (timer_ff == 18'h0);
    assign at_last = (samp_cnt_ff >= avg_last);
    assign pass_done = sample_vld & at_last & ~has_next;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= SEQ_IDLE;
            pend_ff <= 1'b1;
            ch_ff <= 2'd0;
            timer_ff <= 18'h0;
            samp_cnt_ff <= 11'h0;
        end else if (setup_wr) begin
            // any setup write aborts the pass and re-arms
            seq_ff <= SEQ_IDLE;
            pend_ff <= 1'b1;
            samp_cnt_ff <= 11'h0;
        end else begin
            case (seq_ff)
                SEQ_IDLE: begin
                    pend_ff <= 1'b0;
                    if (pend_ff && !shutdown) begin
                        seq_ff <= SEQ_CONV;
                        ch_ff <= load_ch;
                        timer_ff <= ct_cyc - 18'h1;
                        samp_cnt_ff <= 11'h0;
                    end
                end
                SEQ_CONV: begin
                    if (timer_ff != 18'h0) begin
                        timer_ff <= timer_ff - 18'h1;
                    end else begin
                        ch_ff <= load_ch;
                        timer_ff <= ct_cyc - 18'h1;
                        if (at_last)
                            samp_cnt_ff <= 11'h0;
                        else
                            samp_cnt_ff <= samp_cnt_ff + 11'h1;
                        if (pass_done && !continuous)
                            seq_ff <= SEQ_IDLE;
                    end
                end
                default: seq_ff <= SEQ_IDLE;
            endcase
        end
    end

    // set beats clear when both land together
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            conv_ready_ff <= 1'b0;
        else if (pass_done)
            conv_ready_ff <= 1'b1;
        else if (setup_wr)
            conv_ready_ff <= 1'b0;
    end

    // ===========================================
    // channel averagers and current
    wire sense_done;
    wire [15:0] rail_clamped;
    reg [15:0] current_ff;
    wire signed [31:0] cur_prod;
    wire signed [31:0] cur_scaled;

    // the rail cannot go negative, so clamp before averaging
    assign rail_clamped = rail_sample[15] ? 16'h0 : rail_sample;

    sample_averager u_rail_avg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .abort(setup_wr),
        .sample_vld(sample_vld & (ch_ff == 2'd0)),
        .last(at_last),
        .shift(avg_shift),
        .sample(rail_clamped),
        .result_ff(rail_res),
        .done_ff()
    );

    sample_averager u_sense_avg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .abort(setup_wr),
        .sample_vld(sample_vld & (ch_ff == 2'd1)),
        .last(at_last),
        .shift(avg_shift),
        .sample(sense_sample),
        .result_ff(sense_res),
        .done_ff(sense_done)
    );

    sample_averager u_temp_avg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .abort(setup_wr),
        .sample_vld(sample_vld & (ch_ff == 2'd2)),
        .last(at_last),
        .shift(avg_shift),
        .sample(temp_sample),
        .result_ff(temp_result),
        .done_ff()
    );

    // narrow range has four times finer counts, so shift less
    assign cur_prod = $signed(sense_res) * $signed({1'b0, cal_ff});
    assign cur_scaled = range_ff ? (cur_prod >>> `CUR_SHIFT_NARROW) :
                        (cur_prod >>> `CUR_SHIFT_WIDE);

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            current_ff <= 16'h0;
        else if (sense_done)
            current_ff <= cur_scaled[15:0];
    end

    assign sda_out = sda_out_ff;
    assign sda_oe_n = sda_oe_n_ff;
    assign sense_range_select = range_ff;
    assign conv_active = seq_ff;
    assign conv_chan = ch_ff;
    assign conv_ready = conv_ready_ff;
    assign current_result = current_ff;

endmodule

// ==== hw/pwrmon_defines.vh ====
// constants for the power monitor converter setup block
// assumes one 50 MHz core clock and a serial register link
// Operation
// - mode field 15-12, reset Fh, 0h/8h shutdown
// - codes 1h-7h single pass, bit per channel
// - codes 9h-Eh repeat chosen channels continuously
// - rail conversion time field 11-9, reset 5h
// - sense conversion time field 8-6, reset 5h
// - temperature conversion time field 5-3, reset 5h
// - averaging count field 2-0, 1 to 1024
// - one averaging count for every enabled channel
// - results written only after full averaging run
// - 15-bit calibration constant, reset 1000h, bit15 zero
// - calibration constant scales the current result
// - sense result signed, 5 or 1.25 uV
// - rail result signed, never negative, 3.125 mV
// - range bit 4 selects sense full scale
// - ready flag raised when a pass completes
`ifndef PWRMON_DEFINES_VH
`define PWRMON_DEFINES_VH

// ===========================================
// register pointers
`define REG_SYSCFG 8'h00
`define REG_SETUP 8'h01
`define REG_CAL 8'h02
`define REG_SENSE 8'h04
`define REG_RAIL 8'h05

// ===========================================
// reset values and fields
`define SETUP_RST 16'hFB68
`define CAL_RST 15'h1000
`define RANGE_RST 1'b0
`define F_MODE 15:12
`define F_RAIL_CT 11:9
`define F_SENSE_CT 8:6
`define F_TEMP_CT 5:3
`define F_AVG 2:0
`define F_CAL 14:0
`define B_RANGE 4
`define MODE_ALL_CONT 4'hE

// ===========================================
// timing
`define CLK_MHZ 50
`define CT_US_0 50
`define CT_US_1 84
`define CT_US_2 150
`define CT_US_3 280
`define CT_US_4 540
`define CT_US_5 1052
`define CT_US_6 2074
`define CT_US_7 4120

// ===========================================
// averaging: index of last sample, shift for the mean
`define AVG_LAST_0 11'h000
`define AVG_LAST_1 11'h003
`define AVG_LAST_2 11'h00F
`define AVG_LAST_3 11'h03F
`define AVG_LAST_4 11'h07F
`define AVG_LAST_5 11'h0FF
`define AVG_LAST_6 11'h1FF
`define AVG_LAST_7 11'h3FF
`define AVG_SH_0 4'h0
`define AVG_SH_1 4'h2
`define AVG_SH_2 4'h4
`define AVG_SH_3 4'h6
`define AVG_SH_4 4'h7
`define AVG_SH_5 4'h8
`define AVG_SH_6 4'h9
`define AVG_SH_7 4'hA

// ===========================================
// current scaling and link address
`define CUR_SHIFT_WIDE 11
`define CUR_SHIFT_NARROW 9
`define DEV_ADDR_DEF 7'h40

`endif

// ==== hw/sample_averager.v ====
// one channel accumulator producing the mean of a run of samples
// assumes samples and strobes come from logic on core_clk
`timescale 1ns/100ps
`include "pwrmon_defines.vh"

module sample_averager (
    input wire core_clk,
    input wire rst_n,
    input wire abort,
    input wire sample_vld,
    input wire last,
    input wire [3:0] shift,
    input wire [15:0] sample,
    output reg [15:0] result_ff,
    output reg done_ff
);

    // ===========================================
    // accumulate
    reg signed [25:0] acc_ff;
    wire signed [25:0] nxt_acc;
    wire signed [25:0] mean;

    assign nxt_acc = acc_ff + {{10{sample[15]}}, sample};
    assign mean = nxt_acc >>> shift;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 26'h0;
            result_ff <= 16'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (abort) begin
                acc_ff <= 26'h0;
            end else if (sample_vld) begin
                if (last) begin
                    // partial sums never reach the result
                    result_ff <= mean[15:0];
                    done_ff <= 1'b1;
                    acc_ff <= 26'h0;
                end else begin
                    acc_ff <= nxt_acc;
                end
            end
        end
    end

endmodule

// ==== verif/i2c_host_model.sv ====
// host side of the two-wire register link
// scl idles high; sda is wired-and with a pull-up in the bench
`timescale 1ns/100ps
module i2c_host_model (
    input wire core_clk,
    input wire sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // quarter of a 160 ns link period: scl low 4 cycles, high 4
    task automatic step();
        repeat (2) @(posedge core_clk);
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_drv <= b;
        step();
        scl <= 1'b1;
        step();
        step();
        r = sda_line;
        scl <= 1'b0;
        step();
    endtask
    task automatic xbyte(input logic [7:0] t, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) xbit(t[i], q[i]);
    endtask
    // also serves as repeated start with scl low
    task automatic start();
        sda_drv <= 1'b1;
        step();
        scl <= 1'b1;
        step();
        sda_drv <= 1'b0;
        step();
        scl <= 1'b0;
        step();
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        step();
        scl <= 1'b1;
        step();
        sda_drv <= 1'b1;
        step();
    endtask
    task automatic head(input logic [6:0] a, input logic [7:0] p,
                        output logic ok);
        logic [7:0] q;
        logic r0;
        logic r1;
        start();
        xbyte({a, 1'b0}, q);
        xbit(1'b1, r0);
        xbyte(p, q);
        xbit(1'b1, r1);
        ok = !(r0 | r1);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p,
                      input logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic r0;
        logic r1;
        head(a, p, ok);
        xbyte(d[15:8], q);
        xbit(1'b1, r0);
        xbyte(d[7:0], q);
        xbit(1'b1, r1);
        stop();
        ok = ok & !(r0 | r1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p,
                      output logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic r0;
        head(a, p, ok);
        start();
        xbyte({a, 1'b1}, q);
        xbit(1'b1, r0);
        xbyte(8'hFF, q);
        d[15:8] = q;
        xbit(1'b0, r0);
        xbyte(8'hFF, q);
        d[7:0] = q;
        xbit(1'b1, r0);
        stop();
    endtask
endmodule

// ==== verif/pwrmon_adc_setup_asserts.sv ====
// port assertions for the converter setup block
// bound from the bench onto the block's instance
`timescale 1ns/100ps
module pwrmon_adc_setup_asserts (
    input wire core_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe_n,
    input wire conv_active,
    input wire [1:0] conv_chan,
    input wire conv_ready,
    input wire [15:0] temp_result
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ========================================
    // link pin and sequencer relations
    sequence s_idle3;
        !conv_active ##1 !conv_active ##1 !conv_active;
    endsequence
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda data driven high");
    a_sda_moves_low: assert property (
        $changed(sda_oe_n) |-> !$past(scl_in))
        else $error("sda changed while scl high");
    a_ready_after_conv: assert property (
        $rose(conv_ready) |-> $past(conv_active))
        else $error("ready without a conversion");
    a_ready_holds_on: assert property (
        $rose(conv_ready) |=> conv_ready [*8])
        else $error("ready dropped early");
    a_start_clears_ready: assert property (
        $rose(conv_active) |-> !conv_ready)
        else $error("new pass with stale ready");
    a_chan_in_range: assert property (
        conv_active |-> conv_chan != 2'h3)
        else $error("unknown channel converting");
    a_temp_after_run: assert property (
        $changed(temp_result) |->
            $past(conv_active, 2) && $past(conv_chan, 2) == 2'h2)
        else $error("temp result moved off a run");
    a_idle_keeps_temp: assert property (
        s_idle3 |-> $stable(temp_result))
        else $error("temp result moved while idle");
endmodule

// ==== verif/tb_pwrmon_adc_setup.sv ====
// self-checking bench for the converter setup block
// host model drives the link; samples are driven here
`timescale 1ns/100ps
`include "pwrmon_defines.vh"
module tb_pwrmon_adc_setup;
    localparam [17:0] CT0 = 18'h28;
    localparam [17:0] CT7 = 18'hC8;
    localparam [23:0] CONT = {3'h7, 3'h7, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] rail_sample = 16'h1234;
    logic [15:0] sense_sample = 16'hFFF8;
    logic [15:0] temp_sample = 16'h0055;
    wire scl;
    wire sda_drv;
    wire sda_oe_n;
    wire sda_line = sda_drv & sda_oe_n;
    wire range_sel;
    wire conv_active;
    wire conv_ready;
    wire [1:0] conv_chan;
    wire [15:0] current_result;
    wire [15:0] temp_result;
    int n_mismatch = 0;
    int checks = 0;
    always #10 core_clk = ~core_clk;
    pwrmon_adc_setup #(.CT_CYC_0(CT0), .CT_CYC_7(CT7)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_line), .rail_sample(rail_sample),
        .sense_sample(sense_sample), .temp_sample(temp_sample),
        .sda_out(), .sda_oe_n(sda_oe_n),
        .sense_range_select(range_sel), .conv_active(conv_active),
        .conv_chan(conv_chan), .conv_ready(conv_ready),
        .current_result(current_result), .temp_result(temp_result));
    i2c_host_model i_host (.core_clk(core_clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_drv));
    // ========================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        logic ok;
        i_host.wr(`DEV_ADDR_DEF, p, d, ok);
    endtask
    task automatic rchk(input logic [7:0] p, input logic [15:0] e);
        logic [15:0] d;
        logic ok;
        i_host.rd(`DEV_ADDR_DEF, p, d, ok);
        chk(d, e);
    endtask
    task automatic wait_done(output int n, output logic [2:0] m);
        n = 0;
        m = 3'h0;
        for (int i = 0; i < 900 && conv_ready !== 1'b1; i++) begin
            @(posedge core_clk);
            if (conv_active === 1'b1) begin
                n++;
                m[conv_chan] = 1'b1;
            end
        end
        repeat (2) @(posedge core_clk);
    endtask
    task automatic run(input logic [15:0] c, output int n,
                       output logic [2:0] m);
        wr(`REG_SETUP, c);
        wait_done(n, m);
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        logic ok;
        rchk(`REG_SETUP, 16'hFB68);
        rchk(`REG_CAL, 16'h1000);
        rchk(`REG_SENSE, 16'h0000);
        rchk(8'h03, 16'h0000);
        chk({15'h0, range_sel}, 16'h0000);
        wr(`REG_CAL, 16'hFFFF);
        rchk(`REG_CAL, 16'h7FFF);
        wr(`REG_RAIL, 16'h5555);
        rchk(`REG_RAIL, 16'h0000);
        wr(`REG_CAL, 16'h1000);
        i_host.wr(7'h41, `REG_CAL, 16'h0001, ok);
        chk({15'h0, ok}, 16'h0000);
        rchk(`REG_CAL, 16'h1000);
    endtask
    task automatic t_modes();
        int n;
        logic [2:0] m;
        logic [2:0] e;
        for (int c = 0; c < 16; c++) begin
            run({c[3:0], 12'h000}, n, m);
            e = (c < 8) ? c[2:0] : CONT[(c - 8) * 3 +: 3];
            chk({13'h0, m}, {13'h0, e});
            chk({15'h0, conv_ready}, {15'h0, e != 3'h0});
            chk({15'h0, conv_active}, {15'h0, c > 8});
        end
    endtask
    task automatic t_data();
        int n;
        logic [2:0] m;
        run(16'h7000, n, m);
        rchk(`REG_RAIL, 16'h1234);
        rchk(`REG_SENSE, 16'hFFF8);
        chk(temp_result, 16'h0055);
        chk(current_result, 16'hFFF0);
        wr(`REG_SYSCFG, 16'h0010);
        chk({15'h0, range_sel}, 16'h0001);
        rail_sample <= 16'hFFF0;
        run(16'h3000, n, m);
        rchk(`REG_RAIL, 16'h0000);
        chk(current_result, 16'hFFC0);
        wr(`REG_SYSCFG, 16'h0000);
    endtask
    task automatic t_avg();
        int n;
        logic [2:0] m;
        sense_sample <= 16'h0040;
        temp_sample <= 16'h0100;
        wr(`REG_SETUP, 16'h6001);
        repeat (100) @(posedge core_clk);
        chk(temp_result, 16'h0055);
        chk({15'h0, conv_ready}, 16'h0000);
        wait_done(n, m);
        chk(temp_result, 16'h0100);
        chk(current_result, 16'h0080);
    endtask
    task automatic t_ctime();
        int n;
        logic [2:0] m;
        for (int ch = 0; ch < 3; ch++) begin
            run((16'h1000 << ch) | (16'h0E00 >> (3 * ch)), n, m);
            chk({15'h0, n > CT7 - 40 && n <= CT7}, 16'h0001);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_modes();
        t_data();
        t_avg();
        t_ctime();
        tally_and_finish();
    end
    // about 16k cycles expected; nearly four times that means a hang
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind pwrmon_adc_setup pwrmon_adc_setup_asserts i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .conv_active(conv_active), .conv_chan(conv_chan),
    .conv_ready(conv_ready), .temp_result(temp_result));
